// file: rtl/ams_axis_sequencer.sv
// Function
// [RULE_01] two-speed profile only when speed two nonzero
// [RULE_02] final position approached at speed two
// [RULE_03] speed one until switch position, then two
// [RULE_04] speed change follows ramp or acceleration
// [RULE_05] reversed positions: go direct at speed one
// [RULE_06] point-to-point and profile modes, master supplies demands
// [RULE_07] pressure above command: pressure controller takes over
// [RULE_08] two pressure parameter sets, master selects
// [RULE_09] pressure control may run without position control
// [RULE_10] active only with hardware and fieldbus enable
// [RULE_11] enabled without start: hold present position
// [RULE_12] zero speed command gives no motion
// [RULE_13] start off: jog inputs move the axis
// [RULE_14] jog released: stop, hold reached position
// [RULE_15] jog works without position sensor
// [RULE_16] start latches demands and moves to target
// [RULE_17] start removed: stop within deceleration distance
// [RULE_18] remote mode ignores hardware enable and fieldbus
// [RULE_19] remote accepts speed with jog, or position with start
// [RULE_20] not ready: output substitute value
// [RULE_21] ready only when enabled and fault free
// [RULE_22] valve from position output, pressure when limiting
`include "ams_params.svh"

module ams_axis_sequencer
    import ams_pkg::*;
(
    input wire logic CLK_I, // 25 mhz control clock
    input wire logic NRST_I, // async reset, active low
    input wire logic HW_ENABLE_I, // hardware enable pin
    input wire logic FAULT_I, // fault from sensor monitor
    input wire logic POS_VALID_I, // position sensor signal present
    input wire logic [15:0] POS_I, // actual position
    input wire logic [15:0] PRESS_I, // actual pressure
    input wire logic [15:0] POS_CTRL_I, // position compensator output
    input wire logic [15:0] PRESS_CTRL_I, // pressure compensator output
    output logic [15:0] SETPOINT_O, // position setpoint to loop
    output logic [15:0] SPEED_O, // profiled speed magnitude
    output logic DIR_O, // 1 = forward motion
    output logic [15:0] VALVE_O, // valve command
    output logic READY_O, // ready indication
    output logic PRESS_SET_O, // active pressure parameter set
    output logic PRESS_LIMIT_O, // actual pressure above pressure command
    input wire logic [7:0] AWADDR, // axi write address
    input wire logic AWVALID, // axi write address valid
    output logic AWREADY, // axi write address ready
    input wire logic [31:0] WDATA, // axi write data
    input wire logic [3:0] WSTRB, // axi byte strobes
    input wire logic WVALID, // axi write data valid
    output logic WREADY, // axi write data ready
    output logic [1:0] BRESP, // axi write response
    output logic BVALID, // axi write response valid
    input wire logic BREADY, // axi write response ready
    input wire logic [7:0] ARADDR, // axi read address
    input wire logic ARVALID, // axi read address valid
    output logic ARREADY, // axi read address ready
    output logic [31:0] RDATA, // axi read data
    output logic [1:0] RRESP, // axi read response
    output logic RVALID, // axi read data valid
    input wire logic RREADY // axi read data ready
);

    // ************************************************************
    // state of the block
    // ************************************************************
    typedef struct packed {
        logic aw_got; // write address held
        logic [7:0] aw_addr; // held write address
        logic w_got; // write data held
        logic [31:0] w_data; // held write data
        logic [3:0] w_strb; // held strobes
        logic awrdy; // registered ready flags
        logic wrdy;
        logic ardy;
        logic bvalid; // write response pending
        logic [1:0] bresp;
        logic rvalid; // read data pending
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] ctrl; // fieldbus control word
        logic [3:0] rctl; // remote control word
        logic [15:0] v1; // speed_one_command
        logic [15:0] v2; // speed_two_command
        logic [15:0] p1; // switch_position_command
        logic [15:0] p2; // final_position_command
        logic [15:0] pcmd; // pressure command
        logic [15:0] ramp; // speed ramp step
        logic [15:0] accel; // profile generator acceleration
        logic [15:0] decel; // deceleration distance
        logic [15:0] nrv; // not_ready_output_value
        logic [15:0] rspd; // remote speed
        logic [15:0] rpos; // remote position
        logic en_s1; // enable pin sync stage one
        logic en_s2; // enable pin sync stage two
        logic start_d; // start seen last cycle
        ams_state_t st; // sequencer state
        logic [31:0] sp; // setpoint, 16 fraction bits
        logic [15:0] spd; // current speed
        logic dir; // motion direction
        logic [15:0] tgt; // latched end position
        logic [15:0] sw; // latched switch position
        logic [15:0] lv1; // latched first speed
        logic [15:0] lv2; // latched second speed
        logic two; // two-speed profile active
        logic phase2; // running at second speed
        logic [15:0] valve; // valve command
        logic ready; // ready flag
        logic plim; // pressure limiting active
    } ams_regs_t;

    ams_regs_t r, n;

    // byte-lane update of a 16-bit register
    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        logic [15:0] v;
        v = old;
        if (s[0]) begin
            v[7:0] = d[7:0];
        end
        if (s[1]) begin
            v[15:8] = d[15:8];
        end
        return v;
    endfunction

    // working values of the combinational process
    logic remote, en, start, jf, jr, ramp_sel, fire_wr;
    logic [15:0] spd_cmd, pos_cmd, v2_cmd, cur, rem, step, vset;
    logic [31:0] vlim, nxt_sp;
    logic arrive, passed;

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        n = r;
        // ---------------- enable pin synchroniser ----------------
        n.en_s1 = HW_ENABLE_I;
        n.en_s2 = r.en_s1;

        // ---------------- axi write channels ----------------
        if (AWVALID && r.awrdy) begin
            n.aw_got = 1'b1;
            n.aw_addr = AWADDR;
        end
        if (WVALID && r.wrdy) begin
            n.w_got = 1'b1;
            n.w_data = WDATA;
            n.w_strb = WSTRB;
        end
        if (r.bvalid && BREADY) begin
            n.bvalid = 1'b0;
        end
        // write fires once both halves are held, in either order
        fire_wr = r.aw_got && r.w_got && !r.bvalid;
        if (fire_wr) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `AMS_RESP_OKAY;
            unique case (r.aw_addr)
                `AMS_OFS_CTRL: n.ctrl = r.w_strb[0] ? r.w_data[7:0] : r.ctrl;
                `AMS_OFS_SPEED1: n.v1 = wr16(r.v1, r.w_data, r.w_strb);
                `AMS_OFS_SPEED2: n.v2 = wr16(r.v2, r.w_data, r.w_strb);
                `AMS_OFS_SWPOS: n.p1 = wr16(r.p1, r.w_data, r.w_strb);
                `AMS_OFS_FINPOS: n.p2 = wr16(r.p2, r.w_data, r.w_strb);
                `AMS_OFS_PRESS: n.pcmd = wr16(r.pcmd, r.w_data, r.w_strb);
                `AMS_OFS_RAMP: n.ramp = wr16(r.ramp, r.w_data, r.w_strb);
                `AMS_OFS_ACCEL: n.accel = wr16(r.accel, r.w_data, r.w_strb);
                `AMS_OFS_DECEL: n.decel = wr16(r.decel, r.w_data, r.w_strb);
                `AMS_OFS_NRVAL: n.nrv = wr16(r.nrv, r.w_data, r.w_strb);
                `AMS_OFS_RCTRL:
                    n.rctl = r.w_strb[0] ? r.w_data[3:0] : r.rctl;
                `AMS_OFS_RSPEED: n.rspd = wr16(r.rspd, r.w_data, r.w_strb);
                `AMS_OFS_RPOS: n.rpos = wr16(r.rpos, r.w_data, r.w_strb);
                // read-only or unmapped: refused with slave error
                default: n.bresp = `AMS_RESP_SLVERR;
            endcase
        end

        // ---------------- axi read channel ----------------
        if (r.rvalid && RREADY) begin
            n.rvalid = 1'b0;
        end
        if (ARVALID && r.ardy) begin
            n.rvalid = 1'b1;
            n.rresp = `AMS_RESP_OKAY;
            n.rdata = 32'h00000000;
            unique case (ARADDR)
                `AMS_OFS_CTRL: n.rdata[7:0] = r.ctrl;
                `AMS_OFS_SPEED1: n.rdata[15:0] = r.v1;
                `AMS_OFS_SPEED2: n.rdata[15:0] = r.v2;
                `AMS_OFS_SWPOS: n.rdata[15:0] = r.p1;
                `AMS_OFS_FINPOS: n.rdata[15:0] = r.p2;
                `AMS_OFS_PRESS: n.rdata[15:0] = r.pcmd;
                `AMS_OFS_RAMP: n.rdata[15:0] = r.ramp;
                `AMS_OFS_ACCEL: n.rdata[15:0] = r.accel;
                `AMS_OFS_DECEL: n.rdata[15:0] = r.decel;
                `AMS_OFS_NRVAL: n.rdata[15:0] = r.nrv;
                `AMS_OFS_RCTRL: n.rdata[3:0] = r.rctl;
                `AMS_OFS_RSPEED: n.rdata[15:0] = r.rspd;
                `AMS_OFS_RPOS: n.rdata[15:0] = r.rpos;
                `AMS_OFS_STATUS: begin
                    n.rdata[`AMS_ST_READY] = r.ready;
                    n.rdata[`AMS_ST_PLIM] = r.plim;
                    n.rdata[`AMS_ST_MOVING] =
                        (r.st == AMS_MOVE) || (r.st == AMS_STOP);
                    n.rdata[`AMS_ST_JOG] = (r.st == AMS_JOG);
                    n.rdata[`AMS_ST_PHASE2] = r.phase2;
                    n.rdata[`AMS_ST_HWEN] = r.en_s2;
                    n.rdata[`AMS_ST_DIR] = r.dir;
                end
                `AMS_OFS_ACTPOS: n.rdata[15:0] = POS_I;
                `AMS_OFS_SETPT: n.rdata[15:0] = r.sp[31:16];
                `AMS_OFS_VALVE: n.rdata[15:0] = r.valve;
                default: n.rresp = `AMS_RESP_SLVERR;
            endcase
        end

        // ---------------- command sources ----------------
        // remote mode takes enable, start and jog from the pc tool word, not from pin and bus
        remote = r.rctl[`AMS_RCTL_ON]; // RULE_18
        en = remote ||
             (r.en_s2 && r.ctrl[`AMS_CTRL_ENABLE]); // RULE_10
        start = remote ? r.rctl[`AMS_RCTL_START]
                       : r.ctrl[`AMS_CTRL_START]; // RULE_19
        jf = remote ? r.rctl[`AMS_RCTL_JOG_FWD] : r.ctrl[`AMS_CTRL_JOG_FWD];
        jr = remote ? r.rctl[`AMS_RCTL_JOG_REV] : r.ctrl[`AMS_CTRL_JOG_REV];
        spd_cmd = remote ? r.rspd : r.v1; // RULE_19
        pos_cmd = remote ? r.rpos : r.p2; // RULE_06
        // the pc tool gives one speed, so no two-speed profile there
        v2_cmd = remote ? 16'h0000 : r.v2;
        // profile generator mode swaps the ramp for the acceleration
        ramp_sel = r.ctrl[`AMS_CTRL_NCMODE];
        step = ramp_sel ? r.accel : r.ramp; // RULE_04
        n.start_d = start;

        // ---------------- motion profile ----------------
        cur = r.sp[31:16];
        rem = r.dir ? (r.tgt - cur) : (cur - r.tgt);
        passed = r.dir ? (cur >= r.sw) : (cur <= r.sw);
        if (r.st == AMS_MOVE && r.two && passed) begin
            n.phase2 = 1'b1; // RULE_03
        end
        // second speed only after the switch position
        vset = (r.two && r.phase2) ? r.lv2 : r.lv1; // RULE_02
        // stroke-dependent braking near the end position
        vlim = {16'h0000, vset};
        if (r.st != AMS_JOG && rem <= r.decel &&
            ({16'h0000, rem} << `AMS_DEC_SHIFT) < {16'h0000, vset}) begin
            vlim = ({16'h0000, rem} << `AMS_DEC_SHIFT) + 32'h00000001;
        end
        // ramp toward the limit rather than stepping
        n.spd = r.spd;
        if ({16'h0000, r.spd} + {16'h0000, step} <= vlim) begin
            n.spd = r.spd + step; // RULE_04
        end else if ({16'h0000, r.spd} > vlim + {16'h0000, step}) begin
            n.spd = r.spd - step;
        end else begin
            n.spd = vlim[15:0];
        end
        nxt_sp = r.dir ? (r.sp + {16'h0000, r.spd})
                       : (r.sp - {16'h0000, r.spd});
        arrive = r.dir ? (nxt_sp[31:16] >= r.tgt)
                       : (nxt_sp[31:16] <= r.tgt);

        // ---------------- sequencer ----------------
        unique case (r.st)
            AMS_OFF: begin
                n.spd = 16'h0000;
                if (en) begin
                    n.sp = {POS_I, 16'h0000}; // RULE_11
                    n.st = AMS_HOLD;
                end
            end
            AMS_HOLD: begin
                n.spd = 16'h0000;
                if (start && !r.start_d && spd_cmd != 16'h0000) begin
                    // latch all demands on the start edge
                    n.tgt = pos_cmd; // RULE_16
                    n.sw = r.p1;
                    n.lv1 = spd_cmd;
                    n.lv2 = v2_cmd;
                    n.dir = pos_cmd > cur;
                    n.phase2 = 1'b0;
                    // reversed positions drive straight at speed one
                    n.two = (v2_cmd != 16'h0000) && // RULE_01
                            ((pos_cmd > cur) ? (r.p1 < pos_cmd)
                                             : (r.p1 > pos_cmd)); // RULE_05
                    n.st = (pos_cmd == cur) ? AMS_HOLD : AMS_MOVE;
                end else if (!start && (jf ^ jr) &&
                             spd_cmd != 16'h0000) begin // RULE_12
                    n.dir = jf; // RULE_13
                    n.lv1 = spd_cmd;
                    n.two = 1'b0;
                    n.phase2 = 1'b0;
                    n.st = AMS_JOG;
                end
            end
            AMS_MOVE, AMS_STOP: begin
                n.sp = nxt_sp;
                if (r.st == AMS_MOVE && !start) begin
                    // new end point one braking distance ahead
                    n.tgt = r.dir ? (cur + r.decel)
                                  : (cur - r.decel); // RULE_17
                    n.st = AMS_STOP;
                end else if (arrive || rem == 16'h0000) begin
                    n.sp = {r.tgt, 16'h0000};
                    n.spd = 16'h0000;
                    n.st = AMS_HOLD;
                end
            end
            AMS_JOG: begin
                n.sp = nxt_sp;
                if (start || !(jf ^ jr) || jf != r.dir) begin // RULE_13
                    // stop at once and regulate where the axis is
                    n.sp = {POS_I, 16'h0000}; // RULE_14
                    n.spd = 16'h0000;
                    n.st = AMS_HOLD;
                end
            end
        endcase
        if (!en) begin
            n.st = AMS_OFF; // RULE_10
            n.spd = 16'h0000;
        end

        // ---------------- ready and valve command ----------------
        n.ready = en && !FAULT_I; // RULE_21
        n.plim = PRESS_I > r.pcmd; // RULE_07
        if (!n.ready) begin
            n.valve = r.nrv; // RULE_20
        end else if (r.ctrl[`AMS_CTRL_PONLY] || n.plim) begin
            n.valve = PRESS_CTRL_I; // RULE_22 RULE_09
        end else if (r.st == AMS_JOG && !POS_VALID_I) begin
            // no feedback: jog drives the valve open loop
            n.valve = r.dir ? r.lv1 : (16'h0000 - r.lv1); // RULE_15
        end else begin
            n.valve = POS_CTRL_I; // RULE_22
        end

        // ---------------- registered bus ready flags ----------------
        n.awrdy = !n.aw_got && !n.bvalid;
        n.wrdy = !n.w_got && !n.bvalid;
        n.ardy = !n.rvalid;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            r <= '0;
            r.st <= AMS_OFF;
            r.awrdy <= 1'b1;
            r.wrdy <= 1'b1;
            r.ardy <= 1'b1;
            r.ramp <= `AMS_RST_RAMP;
            r.accel <= `AMS_RST_ACCEL;
            r.decel <= `AMS_RST_DECEL;
            r.nrv <= `AMS_RST_NRVAL;
        end else begin
            r <= n;
        end
    end

    // ************************************************************
    // outputs straight from the state register
    // ************************************************************
    assign SETPOINT_O = r.sp[31:16];
    assign SPEED_O = r.spd;
    assign DIR_O = r.dir;
    assign VALVE_O = r.valve;
    assign READY_O = r.ready;
    assign PRESS_SET_O = r.ctrl[`AMS_CTRL_PSET]; // RULE_08
    assign PRESS_LIMIT_O = r.plim;
    assign AWREADY = r.awrdy;
    assign WREADY = r.wrdy;
    assign BRESP = r.bresp;
    assign BVALID = r.bvalid;
    assign ARREADY = r.ardy;
    assign RDATA = r.rdata;
    assign RRESP = r.rresp;
    assign RVALID = r.rvalid;

endmodule

// file: shared/ams_params.svh
`ifndef AMS_PARAMS_SVH
`define AMS_PARAMS_SVH

// ****************************************************************
// register byte offsets on the axi4-lite bus
// ****************************************************************
`define AMS_OFS_CTRL 8'h00
`define AMS_OFS_SPEED1 8'h04
`define AMS_OFS_SPEED2 8'h08
`define AMS_OFS_SWPOS 8'h0C
`define AMS_OFS_FINPOS 8'h10
`define AMS_OFS_PRESS 8'h14
`define AMS_OFS_RAMP 8'h18
`define AMS_OFS_ACCEL 8'h1C
`define AMS_OFS_DECEL 8'h20
`define AMS_OFS_NRVAL 8'h24
`define AMS_OFS_RCTRL 8'h28
`define AMS_OFS_RSPEED 8'h2C
`define AMS_OFS_RPOS 8'h30
`define AMS_OFS_STATUS 8'h34
`define AMS_OFS_ACTPOS 8'h38
`define AMS_OFS_SETPT 8'h3C
`define AMS_OFS_VALVE 8'h40

// ****************************************************************
// control register fields (fieldbus word)
// ****************************************************************
`define AMS_CTRL_ENABLE 0
`define AMS_CTRL_START 1
`define AMS_CTRL_JOG_FWD 2
`define AMS_CTRL_JOG_REV 3
`define AMS_CTRL_PSET 4
`define AMS_CTRL_PONLY 5
`define AMS_CTRL_NCMODE 6

// ****************************************************************
// remote control register fields (pc tool word)
// ****************************************************************
`define AMS_RCTL_ON 0
`define AMS_RCTL_START 1
`define AMS_RCTL_JOG_FWD 2
`define AMS_RCTL_JOG_REV 3

// ****************************************************************
// status register fields
// ****************************************************************
`define AMS_ST_READY 0
`define AMS_ST_PLIM 1
`define AMS_ST_MOVING 2
`define AMS_ST_JOG 3
`define AMS_ST_PHASE2 4
`define AMS_ST_HWEN 5
`define AMS_ST_DIR 6

// ****************************************************************
// reset values, scaling and bus answers
// ****************************************************************
`define AMS_RST_RAMP 16'h0010
`define AMS_RST_ACCEL 16'h0010
`define AMS_RST_DECEL 16'h0100
`define AMS_RST_NRVAL 16'h0000
`define AMS_DEC_SHIFT 8
`define AMS_RESP_OKAY 2'b00
`define AMS_RESP_SLVERR 2'b10

`endif

// file: shared/ams_pkg.sv
package ams_pkg;

    // motion sequencer states
    typedef enum logic [2:0] {
        AMS_OFF,
        AMS_HOLD,
        AMS_MOVE,
        AMS_STOP,
        AMS_JOG
    } ams_state_t;

endpackage

// file: bench/ams_axis_sequencer_asserts.sv
module ams_axis_sequencer_asserts (
    input wire logic CLK_I, // clock
    input wire logic NRST_I, // reset, low
    input wire logic FAULT_I, // fault
    input wire logic READY_O, // ready
    input wire logic [15:0] SPEED_O, // speed
    input wire logic [15:0] SETPOINT_O, // setpoint
    input wire logic AWVALID, // aw valid
    input wire logic AWREADY, // aw ready
    input wire logic WVALID, // w valid
    input wire logic WREADY, // w ready
    input wire logic BVALID, // b valid
    input wire logic BREADY, // b ready
    input wire logic [1:0] BRESP, // b code
    input wire logic ARVALID, // ar valid
    input wire logic ARREADY, // ar ready
    input wire logic RVALID, // r valid
    input wire logic RREADY, // r ready
    input wire logic [31:0] RDATA // r data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);
    // fault drops ready next cycle
    chk_fault_ready: assert property (
        FAULT_I |=> !READY_O) else $error("ready in fault");
    // no profiled speed while off
    chk_idle_speed: assert property (
        !READY_O [*3] |-> SPEED_O == 16'h0000) else $error("speed while off");
    // setpoint moves one unit a cycle at most
    chk_setpt_step: assert property (
        SPEED_O != 16'h0000 && $past(SPEED_O) != 16'h0000 |->
        (SETPOINT_O - $past(SETPOINT_O)) inside {16'h0000, 16'h0001, 16'hFFFF})
        else $error("setpoint jumped");
    chk_aw_drop: assert property (
        AWVALID && AWREADY |=> !AWREADY) else $error("awready stayed high");
    chk_wr_answer: assert property (
        AWVALID && AWREADY && WVALID && WREADY |-> ##[2:3] BVALID)
        else $error("b late");
    chk_b_stand: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("b withdrawn");
    chk_rd_answer: assert property (
        ARVALID && ARREADY |=> RVALID) else $error("read data late");
    chk_r_stand: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("r withdrawn");
    // registers are 16 bits or fewer, upper half reads 0
    chk_r_upper: assert property (
        RVALID |-> RDATA[31:16] == 16'h0000) else $error("upper bits set");
    cover property (READY_O && SPEED_O != 16'h0000);
    cover property (BVALID && BRESP == 2'h2);
    cover property (FAULT_I ##1 !READY_O);
endmodule

bind ams_axis_sequencer ams_axis_sequencer_asserts chk_u (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .FAULT_I(FAULT_I), .READY_O(READY_O),
    .SPEED_O(SPEED_O), .SETPOINT_O(SETPOINT_O), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA)
);

// file: bench/ams_plant.sv
module ams_plant (
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, low
    input wire logic [15:0] setpt_i, // setpoint
    output logic [15:0] pos_o // axis position
);
    timeunit 1ns;
    timeprecision 1ps;
    // stiff axis, one unit a cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_o <= 16'h0020;
        end else if (pos_o != setpt_i) begin
            pos_o <= (pos_o < setpt_i) ? pos_o + 16'h1 : pos_o - 16'h1;
        end
    end
endmodule

// file: bench/axis_motion_sequencer_bench.sv
`include "ams_params.svh"

module axis_motion_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst_n = 1'h0, hw_en = 1'h0, fault = 1'h0, pos_ok = 1'h1;
    logic [15:0] press = 16'h0, pos_ctl = 16'h1111, prs_ctl = 16'h2222;
    logic [15:0] pos, setpt, speed, valve, keep;
    logic dir, ready, pset, plim, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_d;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [1:0] bresp, rresp;
    int err_count = 0, tests_run = 0;

    always #20 clk = ~clk;

    ams_plant plant_u (.clk_i(clk), .rst_n_i(rst_n), .setpt_i(setpt),
        .pos_o(pos));
    ams_axis_sequencer dut_u (.CLK_I(clk), .NRST_I(rst_n),
        .HW_ENABLE_I(hw_en), .FAULT_I(fault), .POS_VALID_I(pos_ok),
        .POS_I(pos), .PRESS_I(press), .POS_CTRL_I(pos_ctl),
        .PRESS_CTRL_I(prs_ctl), .SETPOINT_O(setpt), .SPEED_O(speed),
        .DIR_O(dir), .VALVE_O(valve), .READY_O(ready), .PRESS_SET_O(pset),
        .PRESS_LIMIT_O(plim), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
        .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic tmo();
        err_count++;
        test_done();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    // one write, both halves offered at once
    task automatic w(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r = `AMS_RESP_OKAY);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50 && bvalid !== 1'h1; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        if (bvalid !== 1'h1) tmo();
        bready <= 1'h0;
        chk(bresp, r);
    endtask
    task automatic ctl(input logic [7:0] v);
        w(`AMS_OFS_CTRL, {24'h0, v});
    endtask
    task automatic rd(input logic [7:0] a,
        input logic [1:0] r = `AMS_RESP_OKAY);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50 && rvalid !== 1'h1; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end
        if (rvalid !== 1'h1) tmo();
        rready <= 1'h0;
        rd_d = rdata;
        chk(rresp, r);
    endtask
    task automatic ph(input logic [31:0] e);
        rd(`AMS_OFS_STATUS);
        chk(rd_d[`AMS_ST_PHASE2], e);
    endtask
    // bounded wait on setpoint or speed
    task automatic wt(input logic s, input logic [15:0] v);
        int n;
        for (n = 0; n < 5000 && (s ? speed : setpt) !== v; n++) @(posedge clk);
        if ((s ? speed : setpt) !== v) tmo();
    endtask

    initial begin
        cyc(5);
        rst_n <= 1'h1;
        rd(`AMS_OFS_RAMP);
        chk(rd_d, 32'h10);
        rd(`AMS_OFS_DECEL);
        chk(rd_d, 32'h100);
        rd(8'h80, `AMS_RESP_SLVERR);
        chk(rd_d, 32'h0);
        w(`AMS_OFS_STATUS, 32'h7F, `AMS_RESP_SLVERR);
        w(`AMS_OFS_NRVAL, 32'h1234);
        w(`AMS_OFS_PRESS, 32'h100);
        w(`AMS_OFS_DECEL, 32'h8);
        w(`AMS_OFS_RAMP, 32'h400);
        chk(valve, 32'h1234);
        chk(ready, 32'h0);
        hw_en <= 1'h1;
        ctl(8'h1);
        cyc(4);
        chk(ready, 32'h1);
        chk(setpt, pos);
        chk(valve, pos_ctl);
        w(`AMS_OFS_FINPOS, 32'h40);
        ctl(8'h3);
        keep = setpt;
        cyc(20);
        chk(setpt, keep);
        ctl(8'h1);
        w(`AMS_OFS_SPEED1, 32'h8000);
        ctl(8'h3);
        wt(1'h0, 16'h30);
        ph(32'h0);
        wt(1'h0, 16'h40);
        ctl(8'h1);
        w(`AMS_OFS_SPEED2, 32'h4000);
        w(`AMS_OFS_SWPOS, 32'h60);
        w(`AMS_OFS_FINPOS, 32'h80);
        ctl(8'h3);
        wt(1'h0, 16'h70);
        ph(32'h1);
        wt(1'h0, 16'h80);
        ctl(8'h1);
        w(`AMS_OFS_SWPOS, 32'hC0);
        w(`AMS_OFS_FINPOS, 32'hA0);
        ctl(8'h3);
        wt(1'h0, 16'h90);
        ph(32'h0);
        wt(1'h0, 16'hA0);
        ctl(8'h1);
        w(`AMS_OFS_FINPOS, 32'h200);
        ctl(8'h3);
        wt(1'h0, 16'hB0);
        ctl(8'h1);
        wt(1'h1, 16'h0);
        chk({31'h0, setpt <= 16'hC0}, 32'h1);
        ctl(8'h5);
        cyc(60);
        chk(dir, 32'h1);
        ctl(8'h1);
        wt(1'h1, 16'h0);
        keep = setpt;
        cyc(20);
        chk(setpt, keep);
        ctl(8'h9);
        cyc(20);
        chk(dir, 32'h0);
        pos_ok <= 1'h0;
        ctl(8'h5);
        cyc(5);
        chk(valve, 32'h8000);
        chk(dir, 32'h1);
        pos_ok <= 1'h1;
        press <= 16'h200;
        ctl(8'h11);
        wt(1'h1, 16'h0);
        chk(plim, 32'h1);
        chk(valve, prs_ctl);
        chk(pset, 32'h1);
        press <= 16'h0;
        ctl(8'h21);
        cyc(3);
        chk(plim, 32'h0);
        chk(valve, prs_ctl);
        fault <= 1'h1;
        cyc(3);
        chk(ready, 32'h0);
        chk(valve, 32'h1234);
        fault <= 1'h0;
        hw_en <= 1'h0;
        ctl(8'h0);
        w(`AMS_OFS_RSPEED, 32'h8000);
        w(`AMS_OFS_RPOS, 32'h50);
        w(`AMS_OFS_RCTRL, 32'h1);
        cyc(4);
        chk(ready, 32'h1);
        w(`AMS_OFS_RCTRL, 32'h3);
        wt(1'h0, 16'h50);
        test_done();
    end
endmodule
